/* File: core/serial_pin_invert_map.vh */
// Register map and constants for the serial pin function and inversion block
// **************************************************************************
// **************************************************************************
`ifndef SERIAL_PIN_INVERT_MAP_VH
`define SERIAL_PIN_INVERT_MAP_VH

// Register index as printed; byte address is four times the index
`define SPI_CTRL_INDEX 16'hff91
`define SPI_CTRL_ADDR 18'h3_fe44
`define SPI_ADDR_W 18
`define SPI_CTRL_RESET 8'hc0
`define SPI_RSVD_MASK 8'hc0
`define SPI_CH2_SEL_BIT 5
`define SPI_CH1_SEL_BIT 4
`define SPI_CH2_TXINV_BIT 3
`define SPI_CH2_RXINV_BIT 2
`define SPI_CH1_TXINV_BIT 1
`define SPI_CH1_RXINV_BIT 0

`endif

/* File: core/pin_path.v */
// One channel of pin routing and data inversion
`timescale 1ns/1ps
module pin_path (
    input wire txpin_select_i,
    input wire tx_invert_i,
    input wire rx_invert_i,
    input wire tx_data_i,
    input wire gpio_out_i,
    input wire gpio_oe_n_i,
    input wire pin_in_i,
    output wire pin_out_o,
    output wire pin_oe_n_o,
    output wire rx_data_o
);
    // Combinational on purpose: a setting change shows on the line at once
    wire tx_pol;
    assign tx_pol = tx_data_i ^ tx_invert_i;
    assign pin_out_o = txpin_select_i ? tx_pol : gpio_out_i;
    // Transmit function always drives the pin
    assign pin_oe_n_o = txpin_select_i ? 1'b0 : gpio_oe_n_i;
    assign rx_data_o = pin_in_i ^ rx_invert_i;
endmodule // pin_path

/* File: core/serial_pin_invert_mux.v */
// Control register and pin muxing for two serial channels
`timescale 1ns/1ps
`include "serial_pin_invert_map.vh"
module serial_pin_invert_mux (
    input wire core_clk_i,
    input wire rstn_i,
    input wire [17:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire ch1_tx_data_i,
    input wire ch2_tx_data_i,
    output wire ch1_rx_data_o,
    output wire ch2_rx_data_o,
    input wire port3_bit5_out_i,
    input wire port3_bit5_oe_n_i,
    input wire port4_bit2_out_i,
    input wire port4_bit2_oe_n_i,
    output wire ch1_serial_out_pin_o,
    output wire ch1_serial_out_pin_oe_n_o,
    output wire ch2_serial_out_pin_o,
    output wire ch2_serial_out_pin_oe_n_o,
    input wire ch1_serial_in_pin_i,
    input wire ch2_serial_in_pin_i
);
    // **********************************************************************
    // Constants
    // **********************************************************************
    localparam [7:0] CTRL_RESET = `SPI_CTRL_RESET;
    localparam [7:0] RSVD_MASK = `SPI_RSVD_MASK;
    localparam [0:0] CH2_SEL_RESET = CTRL_RESET[`SPI_CH2_SEL_BIT];
    localparam [0:0] CH1_SEL_RESET = CTRL_RESET[`SPI_CH1_SEL_BIT];
    localparam [0:0] CH2_TXINV_RESET = CTRL_RESET[`SPI_CH2_TXINV_BIT];
    localparam [0:0] CH2_RXINV_RESET = CTRL_RESET[`SPI_CH2_RXINV_BIT];
    localparam [0:0] CH1_TXINV_RESET = CTRL_RESET[`SPI_CH1_TXINV_BIT];
    localparam [0:0] CH1_RXINV_RESET = CTRL_RESET[`SPI_CH1_RXINV_BIT];

    // **********************************************************************
    // Declarations
    // **********************************************************************
    reg ack_r;
    reg ack_nxt;
    reg ctrl_hit;
    wire bus_active;
    wire first_cycle;
    reg wr_take;
    reg rd_take;
    wire [7:0] wr_byte;
    reg [7:0] ctrl_view;
    reg [31:0] readdata_nxt;
    // One flip-flop per field; bits 7 and 6 have none
    reg ch2_txpin_select_r;
    reg ch2_txpin_select_nxt;
    reg ch1_txpin_select_r;
    reg ch1_txpin_select_nxt;
    reg ch2_tx_invert_r;
    reg ch2_tx_invert_nxt;
    reg ch2_rx_invert_r;
    reg ch2_rx_invert_nxt;
    reg ch1_tx_invert_r;
    reg ch1_tx_invert_nxt;
    reg ch1_rx_invert_r;
    reg ch1_rx_invert_nxt;

    // **********************************************************************
    // Register bus: decode
    // **********************************************************************
    always @* begin
        ctrl_hit = 1'b0;
        if (avs_address_i == `SPI_CTRL_ADDR) begin
            ctrl_hit = 1'b1;
        end else begin
            ctrl_hit = 1'b0;
        end
    end

    assign bus_active = avs_read_i | avs_write_i;
    // Exactly one wait cycle per access keeps read data registered
    assign first_cycle = bus_active & ~ack_r;
    assign avs_waitrequest_o = first_cycle;
    assign wr_byte = avs_writedata_i[7:0];

    // **********************************************************************
    // Register bus: access qualify
    // **********************************************************************
    // Writes land at the edge where the master sees waitrequest low
    always @* begin
        wr_take = 1'b0;
        if (avs_write_i && ack_r && ctrl_hit && avs_byteenable_i[0]) begin
            wr_take = 1'b1;
        end
    end

    // Read data is loaded in the wait cycle, so it stands when taken
    always @* begin
        rd_take = 1'b0;
        if (avs_read_i && first_cycle) begin
            rd_take = 1'b1;
        end
    end

    // **********************************************************************
    // Register bus: handshake state
    // **********************************************************************
    // Back-to-back requests are fine: ack_r clears at the answer edge
    always @* begin
        ack_nxt = first_cycle;
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // **********************************************************************
    // Register bus: read data
    // **********************************************************************
    // Reserved bits have no storage; they are forced high here
    always @* begin
        ctrl_view = RSVD_MASK;
        ctrl_view[`SPI_CH2_SEL_BIT] = ch2_txpin_select_r;
        ctrl_view[`SPI_CH1_SEL_BIT] = ch1_txpin_select_r;
        ctrl_view[`SPI_CH2_TXINV_BIT] = ch2_tx_invert_r;
        ctrl_view[`SPI_CH2_RXINV_BIT] = ch2_rx_invert_r;
        ctrl_view[`SPI_CH1_TXINV_BIT] = ch1_tx_invert_r;
        ctrl_view[`SPI_CH1_RXINV_BIT] = ch1_rx_invert_r;
    end

    always @* begin
        readdata_nxt = avs_readdata_o;
        if (rd_take && ctrl_hit) begin
            readdata_nxt = {24'h00_0000, ctrl_view};
        end else if (rd_take) begin
            readdata_nxt = 32'h0000_0000;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_readdata_o <= readdata_nxt;
        end
    end

    // **********************************************************************
    // Channel 2 pin function select
    // **********************************************************************
    // Software enables the transmitter only after this bit is set
    always @* begin
        if (wr_take) begin
            ch2_txpin_select_nxt = wr_byte[`SPI_CH2_SEL_BIT];
        end else begin
            ch2_txpin_select_nxt = ch2_txpin_select_r;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ch2_txpin_select_r <= CH2_SEL_RESET;
        end else begin
            ch2_txpin_select_r <= ch2_txpin_select_nxt;
        end
    end

    // **********************************************************************
    // Channel 1 pin function select
    // **********************************************************************
    // Software enables the transmitter only after this bit is set
    always @* begin
        if (wr_take) begin
            ch1_txpin_select_nxt = wr_byte[`SPI_CH1_SEL_BIT];
        end else begin
            ch1_txpin_select_nxt = ch1_txpin_select_r;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ch1_txpin_select_r <= CH1_SEL_RESET;
        end else begin
            ch1_txpin_select_r <= ch1_txpin_select_nxt;
        end
    end

    // **********************************************************************
    // Channel 2 transmit inversion
    // **********************************************************************
    // A change here flips a frame in flight; software keeps the line idle
    always @* begin
        if (wr_take) begin
            ch2_tx_invert_nxt = wr_byte[`SPI_CH2_TXINV_BIT];
        end else begin
            ch2_tx_invert_nxt = ch2_tx_invert_r;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ch2_tx_invert_r <= CH2_TXINV_RESET;
        end else begin
            ch2_tx_invert_r <= ch2_tx_invert_nxt;
        end
    end

    // **********************************************************************
    // Channel 2 receive inversion
    // **********************************************************************
    // A change here shows the receiver a false edge at once
    always @* begin
        if (wr_take) begin
            ch2_rx_invert_nxt = wr_byte[`SPI_CH2_RXINV_BIT];
        end else begin
            ch2_rx_invert_nxt = ch2_rx_invert_r;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ch2_rx_invert_r <= CH2_RXINV_RESET;
        end else begin
            ch2_rx_invert_r <= ch2_rx_invert_nxt;
        end
    end

    // **********************************************************************
    // Channel 1 transmit inversion
    // **********************************************************************
    // A change here flips a frame in flight; software keeps the line idle
    always @* begin
        if (wr_take) begin
            ch1_tx_invert_nxt = wr_byte[`SPI_CH1_TXINV_BIT];
        end else begin
            ch1_tx_invert_nxt = ch1_tx_invert_r;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ch1_tx_invert_r <= CH1_TXINV_RESET;
        end else begin
            ch1_tx_invert_r <= ch1_tx_invert_nxt;
        end
    end

    // **********************************************************************
    // Channel 1 receive inversion
    // **********************************************************************
    // A change here shows the receiver a false edge at once
    always @* begin
        if (wr_take) begin
            ch1_rx_invert_nxt = wr_byte[`SPI_CH1_RXINV_BIT];
        end else begin
            ch1_rx_invert_nxt = ch1_rx_invert_r;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ch1_rx_invert_r <= CH1_RXINV_RESET;
        end else begin
            ch1_rx_invert_r <= ch1_rx_invert_nxt;
        end
    end

    // **********************************************************************
    // Pin paths
    // **********************************************************************
    // No resync on the receive pins: it would add latency to the data path
    // Channel 1 shares its pin with port3_bit5
    pin_path u_ch1 (
        .txpin_select_i(ch1_txpin_select_r),
        .tx_invert_i(ch1_tx_invert_r),
        .rx_invert_i(ch1_rx_invert_r),
        .tx_data_i(ch1_tx_data_i),
        .gpio_out_i(port3_bit5_out_i),
        .gpio_oe_n_i(port3_bit5_oe_n_i),
        .pin_in_i(ch1_serial_in_pin_i),
        .pin_out_o(ch1_serial_out_pin_o),
        .pin_oe_n_o(ch1_serial_out_pin_oe_n_o),
        .rx_data_o(ch1_rx_data_o)
    );

    // Channel 2 shares its pin with port4_bit2
    pin_path u_ch2 (
        .txpin_select_i(ch2_txpin_select_r),
        .tx_invert_i(ch2_tx_invert_r),
        .rx_invert_i(ch2_rx_invert_r),
        .tx_data_i(ch2_tx_data_i),
        .gpio_out_i(port4_bit2_out_i),
        .gpio_oe_n_i(port4_bit2_oe_n_i),
        .pin_in_i(ch2_serial_in_pin_i),
        .pin_out_o(ch2_serial_out_pin_o),
        .pin_oe_n_o(ch2_serial_out_pin_oe_n_o),
        .rx_data_o(ch2_rx_data_o)
    );
endmodule // serial_pin_invert_mux

/* File: tb/sci_model.sv */
// Serial channel stand-in that feeds transmit data to the block
`timescale 1ns/1ps
module sci_model (
    input wire core_clk_i,
    input wire tx_en_i,
    output logic [1:0] tx_o
);
    logic [1:0] cnt_r = 2'h0;
    // Line rests at mark until the channel is enabled
    assign tx_o = tx_en_i ? cnt_r : 2'h3;
    always @(posedge core_clk_i) cnt_r <= cnt_r + 2'h1;
endmodule // sci_model

/* File: tb/spim_checker.sv */
// Assertions on the pin mux ports
`timescale 1ns/1ps
`include "serial_pin_invert_map.vh"
module spim_checker (
    input wire core_clk_i, rstn_i, avs_read_i, avs_write_i,
    input wire [17:0] avs_address_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i, avs_readdata_o,
    input wire avs_waitrequest_o, ch1_tx_data_i, ch2_tx_data_i,
    input wire ch1_rx_data_o, ch2_rx_data_o, ch1_serial_in_pin_i,
    input wire ch2_serial_in_pin_i, port3_bit5_out_i, port4_bit2_out_i,
    input wire port3_bit5_oe_n_i, port4_bit2_oe_n_i,
    input wire ch1_serial_out_pin_o, ch2_serial_out_pin_o,
    input wire ch1_serial_out_pin_oe_n_o, ch2_serial_out_pin_oe_n_o
);
    reg [5:0] c_r;
    wire hit = avs_address_i == `SPI_CTRL_ADDR;
    wire wh = avs_write_i && !avs_waitrequest_o && hit && avs_byteenable_i[0];
    // Write lands at the edge where waitrequest is seen low
    wire [5:0] e = c_r;
    always @(posedge core_clk_i or negedge rstn_i)
        if (!rstn_i) c_r <= 6'h00;
        else if (wh) c_r <= avs_writedata_i[5:0];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence rd_done; avs_read_i && !avs_waitrequest_o; endsequence
    chk_ch1_pin: assert property (
        {ch1_serial_out_pin_o, ch1_serial_out_pin_oe_n_o} == (e[4] ?
        {ch1_tx_data_i ^ e[1], 1'b0} : {port3_bit5_out_i, port3_bit5_oe_n_i}))
        else $error("ch1 pin wrong");
    chk_ch2_pin: assert property (
        {ch2_serial_out_pin_o, ch2_serial_out_pin_oe_n_o} == (e[5] ?
        {ch2_tx_data_i ^ e[3], 1'b0} : {port4_bit2_out_i, port4_bit2_oe_n_i}))
        else $error("ch2 pin wrong");
    chk_ch1_rx: assert property (ch1_rx_data_o == (ch1_serial_in_pin_i ^ e[0]))
        else $error("ch1 rx wrong");
    chk_ch2_rx: assert property (ch2_rx_data_o == (ch2_serial_in_pin_i ^ e[2]))
        else $error("ch2 rx wrong");
    chk_rd_value: assert property (rd_done and hit
        |-> avs_readdata_o == {24'h00_0000, 2'h3, c_r}) else $error("read wrong");
    chk_rd_miss: assert property (rd_done and !hit
        |-> avs_readdata_o == 32'h0000_0000) else $error("miss read wrong");
    chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("wait too long");
    chk_rx_flip: assert property (wh && avs_writedata_i[0] != c_r[0]
        ##1 $stable(ch1_serial_in_pin_i)
        |-> ch1_rx_data_o != $past(ch1_rx_data_o))
        else $error("rx flip late");
endmodule // spim_checker
bind serial_pin_invert_mux spim_checker u_chk (.*);

/* File: tb/serial_pin_invert_mux_bench.sv */
// Bench for the serial pin invert mux
`timescale 1ns/1ps
`include "serial_pin_invert_map.vh"
module serial_pin_invert_mux_bench;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, en = 0;
    logic [17:0] a = 0; logic [7:0] d = 0; logic [5:0] g = 6'h3a;
    wire [31:0] q; wire wq; wire [1:0] tx, rx; wire [3:0] p;
    int err_total = 0, checks = 0;
    always #25 clk = !clk;
    sci_model u_sci (.core_clk_i(clk), .tx_en_i(en), .tx_o(tx));
    serial_pin_invert_mux u_dut (.core_clk_i(clk), .rstn_i(rst_n),
        .avs_address_i(a), .avs_read_i(rd), .avs_write_i(wr),
        .avs_byteenable_i(4'h1), .avs_writedata_i({24'h00_0000, d}),
        .avs_readdata_o(q), .avs_waitrequest_o(wq),
        .ch1_tx_data_i(tx[0]), .ch2_tx_data_i(tx[1]),
        .ch1_rx_data_o(rx[0]), .ch2_rx_data_o(rx[1]),
        .port3_bit5_out_i(g[0]), .port3_bit5_oe_n_i(g[1]),
        .port4_bit2_out_i(g[2]), .port4_bit2_oe_n_i(g[3]),
        .ch1_serial_out_pin_o(p[0]), .ch1_serial_out_pin_oe_n_o(p[1]),
        .ch2_serial_out_pin_o(p[2]), .ch2_serial_out_pin_oe_n_o(p[3]),
        .ch1_serial_in_pin_i(g[4]), .ch2_serial_in_pin_i(g[5]));
    task cmp(input string n, input [31:0] e, s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task acc(input w, input [17:0] ad, input [7:0] v, input [31:0] x);
        int n;
        @(posedge clk);
        rd <= !w; wr <= w; a <= ad; d <= v;
        n = 0;
        do begin @(posedge clk); n++; end while (wq !== 1'b0 && n < 20);
        if (wq !== 1'b0) begin err_total++; give_verdict; end
        rd <= 0; wr <= 0;
        if (!w) cmp("readdata", x, q);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        @(negedge clk) cmp("pins", 4'ha, p);
        cmp("rx", 2'h3, rx);
        acc(0, `SPI_CTRL_ADDR, 0, 32'h0000_00c0);
        acc(1, `SPI_CTRL_ADDR, 8'h3f, 0);
        en <= 1;
        acc(0, `SPI_CTRL_ADDR, 0, 32'h0000_00ff);
        @(negedge clk) cmp("pins", {1'b0, ~tx[1], 1'b0, ~tx[0]}, p);
        cmp("rx", 2'h0, rx);
        acc(1, 18'h0_0000, 8'h00, 0);
        acc(0, 18'h0_0000, 0, 0);
        for (int i = 0; i < 64; i++) begin
            g <= i[5:0];
            acc(1, `SPI_CTRL_ADDR, i[7:0], 0);
            acc(0, `SPI_CTRL_ADDR, 0, {24'h00_0000, 2'h3, i[5:0]});
        end
        give_verdict;
    end
endmodule // serial_pin_invert_mux_bench
